// ### shared/cbsc_defs.vh
// constants for the clock buffer smbus control block
// assumes inclusion by bare name from design files
`ifndef CBSC_DEFS_VH
`define CBSC_DEFS_VH
// ----------------------------------------------------------------------
// register indices
// ----------------------------------------------------------------------
`define CBSC_REG_MODE      4'h0
`define CBSC_REG_OEN_LO    4'h1
`define CBSC_REG_OEN_HI    4'h2
`define CBSC_REG_SPARE_A   4'h3
`define CBSC_REG_SPARE_B   4'h4
`define CBSC_REG_MAKER     4'h5
`define CBSC_REG_PART      4'h6
`define CBSC_REG_RBLEN     4'h7
`define CBSC_REG_SPARE_C   4'h8
// ----------------------------------------------------------------------
// field positions in the mode register
// ----------------------------------------------------------------------
`define CBSC_MODE_RB_HI    7
`define CBSC_MODE_RB_LO    6
`define CBSC_MODE_SW_EN    3
`define CBSC_MODE_SW_HI    2
`define CBSC_MODE_SW_LO    1
`define CBSC_MODE_FREQ     0
// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define CBSC_RST_SW_EN     1'b0
`define CBSC_RST_SW_MODE   2'h3
`define CBSC_RST_OEN_LO    8'hFF
`define CBSC_RST_OEN_HI    4'hF
`define CBSC_RST_RBLEN     5'h08
// loop mode codes: low band, bypass, high band
`define CBSC_LOOP_LOBW     2'h0
`define CBSC_LOOP_BYP      2'h1
`define CBSC_LOOP_HIBW     2'h3
// tri-level pin codes
`define CBSC_TRI_LOW       2'h0
`define CBSC_TRI_MID       2'h1
`define CBSC_TRI_HIGH      2'h2
`endif

// ### src/cbsc_sync.v
// two-flop synchroniser bank for inputs from outside sys_clk
// assumes inputs are asynchronous levels
`timescale 1ns/1ps
module cbsc_sync #(
  parameter WIDTH = 1
) (
  // clock and reset
  input  wire             sys_clk,
  input  wire             rst,
  // levels
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] stage1;  // first flop, read only by second
  // ----------------------------------------------------------------------
  // two flop chain
  // ----------------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (rst) begin
      stage1   <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule // cbsc_sync

// ### src/cbsc_top.v
// clock buffer control: output gating and smbus register target
// assumes smbus pins open drain, clock sampled by sys_clk (10 MHz)
// Functional notes
// - power-good low tristates all, loop off
// - cleared enable bit tristates that output
// - enable set and pin low runs output
// - enable set and pin high tristates output
// - block write acks address, index, count, data
// - block read returns count then bytes
// - address from address-select pins only
// - mode readback bits from latched pin
// - soft control bit selects mode source
// - soft mode bits reset to one
// - frequency bit reports latched select pin
// - low enable register, outputs 7..0
// - high enable register, outputs 11..8
// - maker and revision code read-only
// - part code read-only
// - readback count sets block read length
`timescale 1ns/1ps
`include "cbsc_defs.vh"
module cbsc_top #(
  parameter [3:0] REVISION_CODE = 4'h4,  // arbitrary value
  parameter [3:0] VENDOR_CODE   = 4'h5,  // arbitrary value
  parameter [7:0] PART_CODE     = 8'h3A  // arbitrary value
) (
  // clock and reset
  input  wire        sys_clk,
  input  wire        rst,
  // power and straps
  input  wire        power_good_sleep_n,
  input  wire        frequency_select,
  input  wire [1:0]  loop_mode_select_pin,
  input  wire [6:0]  target_address_pins,
  // per-output enable pins, active low
  input  wire [11:0] output_enable_n,
  // output control
  output reg  [11:0] clock_output_pairs_en,
  output reg         feedback_output_pair_en,
  output reg         loop_enable,
  output reg  [1:0]  loop_mode,
  output reg         frequency_is_100m,
  // smbus
  input  wire        smb_clk_i,
  input  wire        smb_dat_i,
  output wire        smb_dat_o,
  output wire        smb_dat_oe
);
  // ----------------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------------
  wire [24:0] sync_bus;       // synchronised pins
  cbsc_sync #(.WIDTH(25)) u_sync (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .async_in ({smb_clk_i, smb_dat_i, power_good_sleep_n, frequency_select,
                loop_mode_select_pin, output_enable_n, target_address_pins}),
    .sync_out (sync_bus)
  );
  wire        scl   = sync_bus[24];
  wire        sda   = sync_bus[23];
  wire        pgood = sync_bus[22];
  wire        fsel  = sync_bus[21];
  wire [1:0]  mpin  = sync_bus[20:19];
  wire [11:0] oen_n = sync_bus[18:7];
  wire [6:0]  taddr = sync_bus[6:0];
  reg         scl_d;          // delayed scl for edges
  reg         sda_d;          // delayed sda for start/stop
  reg         pgood_d;        // delayed power good
  reg         pgood_seen;     // first rise already seen
  wire scl_rise = scl & ~scl_d;
  wire scl_fall = ~scl & scl_d;
  wire start_c  = scl & scl_d & sda_d & ~sda;
  wire stop_c   = scl & scl_d & ~sda_d & sda;
  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  reg        freq_latch;      // latched frequency pin
  reg [1:0]  mode_latch;      // latched loop mode readback code
  reg        soft_en;         // loop soft control enable
  reg [1:0]  soft_mode;       // soft loop mode bits
  reg [7:0]  oen_lo;          // enables, outputs 7..0
  reg [3:0]  oen_hi;          // enables, outputs 11..8
  reg [4:0]  rblen;           // readback count
  // ----------------------------------------------------------------------
  // strap latches
  // ----------------------------------------------------------------------
  // latch on first rise
  always @(posedge sys_clk) begin
    if (rst) begin
      pgood_d    <= 1'b0;
      pgood_seen <= 1'b0;
      freq_latch <= 1'b0;
      mode_latch <= `CBSC_LOOP_LOBW;
    end else begin
      pgood_d <= pgood;
      if (pgood & ~pgood_d & ~pgood_seen) begin
        pgood_seen <= 1'b1;
        freq_latch <= fsel;
        // tri-level pin to readback code
        case (mpin)
          `CBSC_TRI_LOW:  mode_latch <= `CBSC_LOOP_LOBW;
          `CBSC_TRI_MID:  mode_latch <= `CBSC_LOOP_BYP;
          default:        mode_latch <= `CBSC_LOOP_HIBW;
        endcase
      end
    end
  end
  // ----------------------------------------------------------------------
  // output gating
  // ----------------------------------------------------------------------
  wire [11:0] en_bits = {oen_hi, oen_lo};
  wire [1:0]  eff_mode;
  assign eff_mode = soft_en ? soft_mode : mode_latch;
  always @(posedge sys_clk) begin
    if (rst) begin
      clock_output_pairs_en   <= 12'h000;
      feedback_output_pair_en <= 1'b0;
      loop_enable             <= 1'b0;
      loop_mode               <= `CBSC_LOOP_LOBW;
      frequency_is_100m       <= 1'b0;
    end else begin
      loop_mode         <= eff_mode;
      frequency_is_100m <= freq_latch;
      if (!pgood) begin
        clock_output_pairs_en   <= 12'h000;
        feedback_output_pair_en <= 1'b0;
        loop_enable             <= 1'b0;
      end else begin
        clock_output_pairs_en   <= en_bits & ~oen_n;
        feedback_output_pair_en <= 1'b1;
        loop_enable             <= (eff_mode != `CBSC_LOOP_BYP);
      end
    end
  end
  // ----------------------------------------------------------------------
  // smbus target state machine
  // ----------------------------------------------------------------------
  localparam ST_IDLE  = 3'h0;  // wait for start
  localparam ST_ADDR  = 3'h1;  // shift address byte
  localparam ST_ACK   = 3'h2;  // drive ack bit
  localparam ST_RX    = 3'h3;  // shift write byte
  localparam ST_TX    = 3'h4;  // shift read byte
  localparam ST_MACK  = 3'h5;  // sample host ack
  localparam ST_WAIT  = 3'h6;  // ignore until stop or start
  localparam PH_INDEX = 2'h0;  // next rx byte is index
  localparam PH_COUNT = 2'h1;  // next rx byte is count
  localparam PH_DATA  = 2'h2;  // next rx byte is data
  reg [2:0] state;           // bus state
  reg [1:0] phase;           // write byte role
  reg [7:0] shreg;           // shift register
  reg [2:0] bitcnt;          // bit counter
  reg [3:0] index;           // register index
  reg [7:0] wcount;          // remaining write bytes
  reg       rd_mode;         // read transfer
  reg       count_sent;      // byte count already sent
  reg       byte_full;       // eight address bits shifted in
  reg       ack_after_tx;    // ack bit follows tx (host)
  reg       drive_low;       // pull sda low
  reg [7:0] rd_data;         // selected register byte
  wire [7:0] count_byte = {3'h0, rblen} + 8'h01;  // count, bytes 0..rblen
  // register read mux
  always @* begin
    rd_data = 8'h00;
    case (index)
      `CBSC_REG_MODE:   rd_data = {mode_latch, 2'b00, soft_en, soft_mode,
                                   freq_latch};
      `CBSC_REG_OEN_LO: rd_data = oen_lo;
      `CBSC_REG_OEN_HI: rd_data = {4'h0, oen_hi};
      `CBSC_REG_MAKER:  rd_data = {REVISION_CODE, VENDOR_CODE};
      `CBSC_REG_PART:   rd_data = PART_CODE;
      `CBSC_REG_RBLEN:  rd_data = {3'h0, rblen};
      default:          rd_data = 8'h00;
    endcase
  end
  assign smb_dat_o  = 1'b0;
  assign smb_dat_oe = drive_low;
  always @(posedge sys_clk) begin
    if (rst) begin
      scl_d        <= 1'b1;
      sda_d        <= 1'b1;
      state        <= ST_IDLE;
      phase        <= PH_INDEX;
      shreg        <= 8'h00;
      bitcnt       <= 3'h0;
      index        <= 4'h0;
      wcount       <= 8'h00;
      rd_mode      <= 1'b0;
      count_sent   <= 1'b0;
      byte_full    <= 1'b0;
      ack_after_tx <= 1'b0;
      drive_low    <= 1'b0;
      soft_en      <= `CBSC_RST_SW_EN;
      soft_mode    <= `CBSC_RST_SW_MODE;
      oen_lo       <= `CBSC_RST_OEN_LO;
      oen_hi       <= `CBSC_RST_OEN_HI;
      rblen        <= `CBSC_RST_RBLEN;
    end else begin
      scl_d <= scl;
      sda_d <= sda;
      if (stop_c) begin
        // stop ends everything
        state     <= ST_IDLE;
        drive_low <= 1'b0;
      end else if (start_c) begin
        // start or repeated start
        state     <= ST_ADDR;
        byte_full <= 1'b0;
        bitcnt    <= 3'h0;
        drive_low <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: drive_low <= 1'b0;
          ST_ADDR: begin
            if (scl_rise) begin
              shreg     <= {shreg[6:0], sda};
              bitcnt    <= bitcnt + 3'h1;
              byte_full <= (bitcnt == 3'h7);
            end
            // the start's own scl fall must not end the address byte
            if (scl_fall && byte_full) begin
              if (shreg[7:1] == taddr) begin
                rd_mode    <= shreg[0];
                drive_low  <= 1'b1;
                state      <= ST_ACK;
                phase      <= PH_INDEX;
                count_sent <= 1'b0;
              end else begin
                state <= ST_WAIT;
              end
            end
          end
          ST_ACK: begin
            // release ack at its falling edge
            if (scl_fall) begin
              drive_low <= 1'b0;
              bitcnt    <= 3'h0;
              if (rd_mode) begin
                state     <= ST_TX;
                shreg     <= count_sent ? rd_data : count_byte;
                drive_low <= count_sent ? ~rd_data[7] : ~count_byte[7];
                count_sent <= 1'b1;
              end else begin
                state <= ST_RX;
              end
            end
          end
          ST_RX: begin
            if (scl_rise) begin
              shreg  <= {shreg[6:0], sda};
              bitcnt <= bitcnt + 3'h1;
            end
            if (scl_fall && bitcnt == 3'h0) begin
              drive_low <= 1'b1;
              state     <= ST_ACK;
              case (phase)
                PH_INDEX: begin
                  index <= shreg[3:0];
                  phase <= PH_COUNT;
                end
                PH_COUNT: begin
                  wcount <= shreg;
                  phase  <= PH_DATA;
                end
                default: begin
                  if (wcount != 8'h00) begin
                    wcount <= wcount - 8'h01;
                    case (index)
                      `CBSC_REG_MODE: begin
                        soft_en   <= shreg[`CBSC_MODE_SW_EN];
                        soft_mode <= shreg[`CBSC_MODE_SW_HI:`CBSC_MODE_SW_LO];
                      end
                      `CBSC_REG_OEN_LO: oen_lo <= shreg;
                      `CBSC_REG_OEN_HI: oen_hi <= shreg[3:0];
                      `CBSC_REG_RBLEN:  rblen  <= shreg[4:0];
                      default: ;
                    endcase
                  end
                  index <= index + 4'h1;
                end
              endcase
            end
          end
          ST_TX: begin
            // shift out msb first on falling edges
            if (scl_fall) begin
              bitcnt <= bitcnt + 3'h1;
              if (bitcnt == 3'h7) begin
                drive_low <= 1'b0;
                state     <= ST_MACK;
              end else begin
                shreg     <= {shreg[6:0], 1'b0};
                drive_low <= ~shreg[6];
              end
            end
          end
          ST_MACK: begin
            if (scl_rise) begin
              ack_after_tx <= ~sda;
            end
            if (scl_fall) begin
              if (ack_after_tx) begin
                bitcnt    <= 3'h0;
                shreg     <= rd_data;
                drive_low <= ~rd_data[7];
                state     <= ST_TX;
                index <= index + 4'h1;
              end else begin
                state <= ST_WAIT;
              end
            end
          end
          ST_WAIT: drive_low <= 1'b0;
          default: state <= ST_IDLE;
        endcase
      end
    end
  end
endmodule // cbsc_top

// ### testbench/cbsc_top_asserts.sv
// checker for the clock buffer control top, ports only
// assumes binding to cbsc_top, one clock domain on sys_clk
`timescale 1ns/1ps
module cbsc_top_asserts (
  // clock and reset
  input wire        sys_clk,
  input wire        rst,
  // pins
  input wire        power_good_sleep_n,
  input wire [11:0] output_enable_n,
  // outputs
  input wire [11:0] clock_output_pairs_en,
  input wire        feedback_output_pair_en,
  input wire        loop_enable,
  input wire [1:0]  loop_mode,
  input wire        frequency_is_100m,
  // smbus
  input wire        smb_clk_i,
  input wire        smb_dat_o,
  input wire        smb_dat_oe
);
  // ----------------------------------------------------------------
  // helper logic
  // ----------------------------------------------------------------
  logic [11:0] pin_hist [0:5];  // six cycles of enable pins
  logic [11:0] pins_high;       // pins held high all six cycles
  logic [1:0]  freq_moves;      // changes of the latched frequency
  // shift pin history, cleared in reset
  always @(posedge sys_clk) begin
    for (int i = 5; i > 0; i--) pin_hist[i] <= rst ? 12'h000 : pin_hist[i-1];
    pin_hist[0] <= rst ? 12'h000 : output_enable_n;
  end
  assign pins_high = pin_hist[0] & pin_hist[1] & pin_hist[2] & pin_hist[3]
                   & pin_hist[4] & pin_hist[5];
  // count frequency latch moves, saturating
  always @(posedge sys_clk) begin
    if (rst) freq_moves <= 2'h0;
    else if ($changed(frequency_is_100m) && freq_moves != 2'h3)
      freq_moves <= freq_moves + 2'h1;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  pd_quiet_a: assert property (!power_good_sleep_n [*6] |->
    clock_output_pairs_en == 12'h000 && !feedback_output_pair_en
    && !loop_enable) else $error("outputs live in power down");
  reset_quiet_a: assert property (disable iff (1'b0) rst |=>
    clock_output_pairs_en == 12'h000 && !loop_enable && !smb_dat_oe)
    else $error("outputs live after reset");
  fb_runs_a: assert property (power_good_sleep_n [*6] |->
    feedback_output_pair_en) else $error("feedback idle while powered");
  out_needs_fb_a: assert property (clock_output_pairs_en != 12'h000
    |-> feedback_output_pair_en) else $error("output without feedback");
  pin_gate_a: assert property (
    (clock_output_pairs_en & pins_high) == 12'h000)
    else $error("output runs with its enable pin high");
  bypass_off_a: assert property (loop_mode == 2'h1 |-> !loop_enable)
    else $error("loop on in bypass");
  mode_code_a: assert property (loop_mode != 2'h2)
    else $error("illegal loop mode code");
  freq_once_a: assert property (freq_moves <= 2'h1)
    else $error("frequency latch moved twice");
  sda_still_a: assert property (smb_clk_i [*3] |-> $stable(smb_dat_oe))
    else $error("sda moved while scl high");
  dat_low_a: assert property (smb_dat_o == 1'b0)
    else $error("sda driven high");
  // main scenarios reached
  cover property ($rose(smb_dat_oe));
  cover property (loop_mode == 2'h1);
  cover property (clock_output_pairs_en == 12'h30F);
endmodule // cbsc_top_asserts

// ### testbench/cbsc_host.sv
// smbus host model: bit-banged block write and block read
// assumes sda pulled up outside; scl idles high between frames
`timescale 1ns/1ps
module cbsc_host (
  // clock
  input  wire  sys_clk,
  // smbus
  input  wire  sda,
  output logic scl,
  output logic sda_oe
);
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  // quarter of an 800 ns bit
  task automatic q;
    repeat (2) @(posedge sys_clk);
  endtask
  // one bit out, line sampled mid high
  task automatic bit_io(input logic b, output logic r);
    sda_oe <= ~b;
    q;
    scl <= 1'b1;
    q;
    r = sda;
    q;
    scl <= 1'b0;
    q;
  endtask
  // start, also used as repeated start
  task automatic start;
    sda_oe <= 1'b0;
    q;
    scl <= 1'b1;
    q;
    sda_oe <= 1'b1;
    q;
    scl <= 1'b0;
    q;
  endtask
  task automatic stop;
    sda_oe <= 1'b1;
    q;
    scl <= 1'b1;
    q;
    sda_oe <= 1'b0;
    q;
  endtask
  // byte msb first then ack bit; ab is what host puts on ack
  task automatic xbyte(input [7:0] v, input logic ab, output [7:0] r,
                       output logic ackd);
    logic a;
    for (int i = 7; i >= 0; i--) bit_io(v[i], r[i]);
    bit_io(ab, a);
    ackd = ~a;
  endtask
  task automatic blk_write(input [6:0] a, input [3:0] idx, input int n,
                           input [71:0] d, output logic ok);
    logic [7:0] r;
    logic k;
    start;
    xbyte({a, 1'b0}, 1'b1, r, ok);
    xbyte({4'h0, idx}, 1'b1, r, k);
    ok &= k;
    xbyte(n[7:0], 1'b1, r, k);
    ok &= k;
    for (int i = 0; i < n; i++) begin
      xbyte(d[8*i +: 8], 1'b1, r, k);
      ok &= k;
    end
    stop;
  endtask
  task automatic blk_read(input [6:0] a, input [3:0] idx, input int n,
                          output [7:0] cnt, output [127:0] d,
                          output logic ok);
    logic [7:0] r;
    logic k;
    start;
    xbyte({a, 1'b0}, 1'b1, r, ok);
    xbyte({4'h0, idx}, 1'b1, r, k);
    ok &= k;
    start;
    xbyte({a, 1'b1}, 1'b1, r, k);
    ok &= k;
    xbyte(8'hFF, 1'b0, cnt, k);
    d = '0;
    for (int i = 0; i < n; i++) begin
      xbyte(8'hFF, i == n - 1, r, k);
      d[8*i +: 8] = r;
    end
    stop;
  endtask
endmodule // cbsc_host

// ### testbench/tb_cbsc_top.sv
// testbench for the clock buffer smbus control top
// assumes cbsc_host as smbus host and a pull-up on sda
`timescale 1ns/1ps
module tb_cbsc_top;
  localparam [6:0] ADDR = 7'h61;  // strap address
  localparam       LIMIT = 40000; // cycle ceiling
  logic        sys_clk, rst, pg, freq;
  logic [1:0]  mode_pin;
  logic [6:0]  addr_pins;
  logic [11:0] oe_n;
  wire  [11:0] en;
  wire  [1:0]  lmode;
  wire         fb, loop_en, f100, dat_o, dat_oe, scl, h_oe;
  wire         sda = ~(h_oe | (dat_oe & ~dat_o));
  int          num_errors = 0, n_compared = 0, cyc = 0;
  // identity parameters: arbitrary values
  cbsc_top #(.REVISION_CODE(4'h2), .VENDOR_CODE(4'h6), .PART_CODE(8'h5B))
  dut (.sys_clk(sys_clk), .rst(rst), .power_good_sleep_n(pg),
    .frequency_select(freq), .loop_mode_select_pin(mode_pin),
    .target_address_pins(addr_pins), .output_enable_n(oe_n),
    .clock_output_pairs_en(en), .feedback_output_pair_en(fb),
    .loop_enable(loop_en), .loop_mode(lmode), .frequency_is_100m(f100),
    .smb_clk_i(scl), .smb_dat_i(sda), .smb_dat_o(dat_o),
    .smb_dat_oe(dat_oe));
  cbsc_host host (.sys_clk(sys_clk), .sda(sda), .scl(scl), .sda_oe(h_oe));
  always #50 sys_clk = ~sys_clk;
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic end_sim;
    $display("compared %0d mismatched %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      num_errors++;
      end_sim;
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input [3:0] idx, input int n, input [71:0] d);
    logic ok;
    host.blk_write(ADDR, idx, n, d, ok);
    check(ok, 1'b1);
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic rd(input [3:0] idx, input int n, input [7:0] c,
                    input [71:0] e);
    logic [7:0] cnt;
    logic [127:0] d;
    logic ok;
    host.blk_read(ADDR, idx, n, cnt, d, ok);
    check(ok, 1'b1);
    check(cnt, c);
    for (int i = 0; i < n; i++) check(d[8*i +: 8], e[8*i +: 8]);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_defaults;
    rd(4'h0, 9, 8'h09, 72'h00_08_5B_26_00_00_0F_FF_C7);
    check(lmode, 2'h3);
    check(f100, 1'b1);
  endtask
  task automatic t_gating;
    oe_n <= 12'hA5A;
    repeat (8) @(posedge sys_clk);
    check(en, 12'h5A5);
    wr(4'h1, 2, 72'h030F);
    oe_n <= 12'h000;
    repeat (8) @(posedge sys_clk);
    check(en, 12'h30F);
    check(fb, 1'b1);
    rd(4'h1, 2, 8'h09, 72'h030F);
    wr(4'h1, 2, 72'h0FFF);
    check(en, 12'hFFF);
  endtask
  task automatic t_mode;
    logic [1:0] c;
    for (int i = 0; i < 4; i++) if (i != 2) begin
      c = i[1:0];
      wr(4'h0, 1, {64'h0, 5'h01, c, 1'b0});
      check(lmode, c);
      check(loop_en, c != 2'h1);
      rd(4'h0, 1, 8'h09, {64'h0, 5'h19, c, 1'b1});
    end
    wr(4'h0, 1, 72'h06);
    check(lmode, 2'h3);
    rd(4'h0, 1, 8'h09, 72'hC7);
  endtask
  task automatic t_spare_count;
    wr(4'h3, 4, 72'hAA_AA_AA_55);
    rd(4'h3, 4, 8'h09, 72'h5B_26_00_00);
    wr(4'h7, 1, 72'hE2);
    rd(4'h5, 3, 8'h03, 72'h02_5B_26);
    wr(4'h7, 1, 72'h08);
  endtask
  task automatic t_wrong_addr;
    logic ok;
    host.blk_write(ADDR ^ 7'h01, 4'h1, 1, 72'h00, ok);
    check(ok, 1'b0);
    rd(4'h1, 1, 8'h09, 72'hFF);
  endtask
  task automatic t_power;
    pg <= 1'b0;
    freq <= 1'b0;
    mode_pin <= 2'h1;
    repeat (8) @(posedge sys_clk);
    check({en, fb, loop_en}, 14'h0);
    pg <= 1'b1;
    repeat (8) @(posedge sys_clk);
    check({f100, lmode}, 3'h7);
    check({en, fb}, 13'h1FFF);
  endtask
  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    pg = 1'b0;
    freq = 1'b1;
    mode_pin = 2'h2;
    addr_pins = ADDR;
    oe_n = 12'h000;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    pg <= 1'b1;
    repeat (10) @(posedge sys_clk);
    t_defaults;
    t_gating;
    t_mode;
    t_spare_count;
    t_wrong_addr;
    t_power;
    end_sim;
  end
endmodule // tb_cbsc_top
bind cbsc_top cbsc_top_asserts chk (.sys_clk, .rst, .power_good_sleep_n,
  .output_enable_n, .clock_output_pairs_en, .feedback_output_pair_en,
  .loop_enable, .loop_mode, .frequency_is_100m, .smb_clk_i, .smb_dat_o,
  .smb_dat_oe);
